// ===== pkg/dzfv_pkg.sv
/*
 * Shared constants for the DAC zero-flag and left volume control block:
 * register addresses, field positions, write masks, reset values and the
 * pin-function select codes.
 * Assumes a 7-bit register address coming from the device's control port.
 */
package dzfv_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // Register addresses on the control port
    localparam logic [6:0] ADDR_ZERO_FLAG_CONFIG = 7'h66;
    localparam logic [6:0] ADDR_ZERO_PIN_FUNCTION = 7'h67;
    localparam logic [6:0] ADDR_LEFT_VOLUME = 7'h68;

    // dac_zero_flag_config fields
    localparam int unsigned FLAG_POLARITY_SEL_BIT = 0;
    localparam int unsigned FLAG_ZERO_DATA_DIS_BIT = 1;
    localparam int unsigned FLAG_MUTE_VOL_DIS_BIT = 2;
    localparam logic [7:0] ZERO_FLAG_CONFIG_MASK = 8'h07;
    localparam logic [7:0] ZERO_FLAG_CONFIG_RST = 8'h00;

    // dac_zero_pin_function fields
    localparam int unsigned RIGHT_PIN_SEL_LSB = 4;
    localparam int unsigned SHARED_PIN_IRQ_BIT = 6;
    localparam logic [7:0] ZERO_PIN_FUNCTION_MASK = 8'h70;
    localparam logic [7:0] ZERO_PIN_FUNCTION_RST = 8'h00;

    // dac_left_volume: all ones is 0 dBFS
    localparam logic [7:0] LEFT_VOLUME_RST = 8'hFF;
    localparam logic [7:0] LEFT_GAIN_MUTE_CODE = 8'h00;

    typedef enum logic [1:0] {
        DZFV_RSEL_RIGHT = 2'b00,
        DZFV_RSEL_LEFT = 2'b01,
        DZFV_RSEL_EITHER = 2'b10,
        DZFV_RSEL_BOTH = 2'b11
    } dzfv_right_sel_t;

    // Log2 of the gain steps per 6 dB, and the fine-step table scale
    localparam int unsigned FINE_STEPS_LOG2 = 4;
    localparam int unsigned FINE_FRAC_BITS = 15;

endpackage : dzfv_pkg

// ===== src/dzfv_gain_scaler.sv
/*
 * Left channel gain scaler: multiplies a signed sample by the gain that an
 * 8-bit code in 0.375 dB steps selects (all ones is unity).
 * Assumes samples and valid arrive on i_sys_clk; one cycle of latency.
 */
`timescale 1ns/1ps
module dzfv_gain_scaler
    import dzfv_pkg::*;
#(
    parameter int unsigned SAMPLE_W = 24
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_gain_code,
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic i_valid,
    output logic [SAMPLE_W-1:0] o_sample,
    output logic o_valid
);

    localparam int unsigned PROD_W = SAMPLE_W + 17;

    logic [7:0] atten;
    logic [3:0] coarse;
    logic [3:0] fine;
    logic [15:0] fine_gain;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] scaled;
    logic [SAMPLE_W-1:0] o_sample_r;
    logic o_valid_r;

    // Sixteen 0.375 dB steps are taken as one halving (6.0 vs 6.02 dB)
    assign atten = 8'hFF - i_gain_code;
    assign coarse = atten[7:FINE_STEPS_LOG2];
    assign fine = atten[FINE_STEPS_LOG2-1:0];

    always_comb begin
        case (fine)
            4'h0: fine_gain = 16'h7FFF;
            4'h1: fine_gain = 16'h7A98;
            4'h2: fine_gain = 16'h756B;
            4'h3: fine_gain = 16'h7076;
            4'h4: fine_gain = 16'h6BB3;
            4'h5: fine_gain = 16'h6728;
            4'h6: fine_gain = 16'h62CB;
            4'h7: fine_gain = 16'h5E9F;
            4'h8: fine_gain = 16'h5A9D;
            4'h9: fine_gain = 16'h56C9;
            4'hA: fine_gain = 16'h531F;
            4'hB: fine_gain = 16'h4F9B;
            4'hC: fine_gain = 16'h4C3F;
            4'hD: fine_gain = 16'h4906;
            4'hE: fine_gain = 16'h45F0;
            default: fine_gain = 16'h42FC;
        endcase
    end

    assign prod = PROD_W'($signed(i_sample) * $signed({1'b0, fine_gain}));
    assign scaled = prod >>> (FINE_FRAC_BITS + 32'(coarse));

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_sample_r <= '0;
            o_valid_r <= 1'b0;
        end else begin
            o_sample_r <= scaled[SAMPLE_W-1:0];
            o_valid_r <= i_valid;
        end
    end

    assign o_sample = o_sample_r;
    assign o_valid = o_valid_r;

endmodule : dzfv_gain_scaler

// ===== src/dzfv_top.sv
/*
 * DAC zero-flag and left volume control: three control registers on the
 * device's internal register port, zero-flag pin logic and the left gain.
 * Assumes the control-port decoder, the zero-data detectors, mute and the
 * interrupt source all run on i_sys_clk.
 * Right volume comes in already decoded as a zero-code flag.
 */
`timescale 1ns/1ps
module dzfv_top
    import dzfv_pkg::*;
#(
    parameter int unsigned SAMPLE_W = 24
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [6:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_left_mute,
    input wire logic i_right_mute,
    input wire logic i_right_vol_zero,
    input wire logic i_left_zero_data,
    input wire logic i_right_zero_data,
    input wire logic i_irq_req,
    output logic o_left_flag_or_irq_pin,
    output logic o_right_channel_flag_pin,
    input wire logic [SAMPLE_W-1:0] i_left_sample,
    input wire logic i_left_valid,
    output logic [SAMPLE_W-1:0] o_left_sample,
    output logic o_left_valid
);

    logic [7:0] flag_cfg_r;
    logic [7:0] flag_cfg_nxt;
    logic [7:0] pin_fn_r;
    logic [7:0] pin_fn_nxt;
    logic [7:0] left_gain_code_r;
    logic [7:0] left_gain_code_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic left_pin_r;
    logic right_pin_r;

    logic wr_flag_cfg;
    logic wr_pin_fn;
    logic wr_left_vol;
    logic flag_on_mute_vol_disable;
    logic flag_on_zero_data_disable;
    logic flag_polarity_sel;
    logic shared_pin_irq_sel;
    dzfv_right_sel_t right_pin_function_sel;
    logic left_channel_flag;
    logic right_channel_flag;
    logic right_sel_flag;
    logic left_pin_level;
    logic right_pin_level;
    logic sel_flag_cfg;
    logic sel_pin_fn;
    logic sel_left_vol;
    logic left_vol_zero;
    logic [1:0] chan_mute;
    logic [1:0] chan_vol_zero;
    logic [1:0] chan_zero_data;
    logic [1:0] chan_flag;

    // Register decode
    assign sel_flag_cfg = (i_reg_addr == ADDR_ZERO_FLAG_CONFIG);
    assign sel_pin_fn = (i_reg_addr == ADDR_ZERO_PIN_FUNCTION);
    assign sel_left_vol = (i_reg_addr == ADDR_LEFT_VOLUME);
    assign wr_flag_cfg = i_reg_wr && sel_flag_cfg;
    assign wr_pin_fn = i_reg_wr && sel_pin_fn;
    assign wr_left_vol = i_reg_wr && sel_left_vol;

    // Masking keeps reserved bits at zero in storage
    assign flag_cfg_nxt = wr_flag_cfg ?
        (i_reg_wdata & ZERO_FLAG_CONFIG_MASK) : flag_cfg_r;
    assign pin_fn_nxt = wr_pin_fn ?
        (i_reg_wdata & ZERO_PIN_FUNCTION_MASK) : pin_fn_r;
    assign left_gain_code_nxt = wr_left_vol ? i_reg_wdata : left_gain_code_r;

    // Unmapped addresses read back zero
    assign rdata_nxt =
        sel_flag_cfg ? flag_cfg_r :
        sel_pin_fn ? pin_fn_r :
        sel_left_vol ? left_gain_code_r :
        8'h00;

    // Field extraction
    assign flag_on_mute_vol_disable = flag_cfg_r[FLAG_MUTE_VOL_DIS_BIT];
    assign flag_on_zero_data_disable = flag_cfg_r[FLAG_ZERO_DATA_DIS_BIT];
    assign flag_polarity_sel = flag_cfg_r[FLAG_POLARITY_SEL_BIT];
    assign shared_pin_irq_sel = pin_fn_r[SHARED_PIN_IRQ_BIT];
    assign right_pin_function_sel =
        dzfv_right_sel_t'(pin_fn_r[RIGHT_PIN_SEL_LSB +: 2]);

    // Index 0 is the left channel, index 1 the right one
    assign left_vol_zero = (left_gain_code_r == LEFT_GAIN_MUTE_CODE);
    assign chan_mute = {i_right_mute, i_left_mute};
    assign chan_vol_zero = {i_right_vol_zero, left_vol_zero};
    assign chan_zero_data = {i_right_zero_data, i_left_zero_data};

    // Zero data has its own enable; mute and volume zero share one enable
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic vol_term;
        logic data_term;
        assign vol_term = !flag_on_mute_vol_disable &&
            (chan_mute[ch] || chan_vol_zero[ch]);
        assign data_term = !flag_on_zero_data_disable &&
            chan_zero_data[ch];
        assign chan_flag[ch] = vol_term || data_term;
    end

    assign left_channel_flag = chan_flag[0];
    assign right_channel_flag = chan_flag[1];

    // Right pin remapping only takes effect in interrupt mode
    always_comb begin
        case (right_pin_function_sel)
            DZFV_RSEL_RIGHT: right_sel_flag = right_channel_flag;
            DZFV_RSEL_LEFT: right_sel_flag = left_channel_flag;
            DZFV_RSEL_EITHER:
                right_sel_flag = left_channel_flag ||
                    right_channel_flag;
            DZFV_RSEL_BOTH:
                right_sel_flag = left_channel_flag &&
                    right_channel_flag;
            default: right_sel_flag = right_channel_flag;
        endcase
    end

    // Interrupt level is passed as is; polarity applies to flags only
    assign left_pin_level = shared_pin_irq_sel ? i_irq_req :
        (left_channel_flag ^ flag_polarity_sel);
    assign right_pin_level = (shared_pin_irq_sel ? right_sel_flag :
        right_channel_flag) ^ flag_polarity_sel;

    // Reserved bits are masked on the way in, so storage stays clean
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flag_cfg_r <= ZERO_FLAG_CONFIG_RST;
        end else begin
            flag_cfg_r <= flag_cfg_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pin_fn_r <= ZERO_PIN_FUNCTION_RST;
        end else begin
            pin_fn_r <= pin_fn_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            left_gain_code_r <= LEFT_VOLUME_RST;
        end else begin
            left_gain_code_r <= left_gain_code_nxt;
        end
    end

    // Read data holds until the next read; only rvalid marks new data
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= i_reg_rd ? rdata_nxt : rdata_r;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_reg_rd;
        end
    end

    // Pins reset to the inactive active-high level
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            left_pin_r <= 1'b0;
        end else begin
            left_pin_r <= left_pin_level;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            right_pin_r <= 1'b0;
        end else begin
            right_pin_r <= right_pin_level;
        end
    end

    // Gain follows the register at once; no ramp, so big steps may click
    dzfv_gain_scaler #(
        .SAMPLE_W(SAMPLE_W)
    ) u_gain (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_gain_code(left_gain_code_r),
        .i_sample(i_left_sample),
        .i_valid(i_left_valid),
        .o_sample(o_left_sample),
        .o_valid(o_left_valid)
    );

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_left_flag_or_irq_pin = left_pin_r;
    assign o_right_channel_flag_pin = right_pin_r;

endmodule : dzfv_top

// ===== tb/dzfv_props.sv
/* Port checker for dzfv_top: register port, flag pin and sample timing.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module dzfv_props
    import dzfv_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [6:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_irq_req,
    input wire logic o_left_flag_or_irq_pin,
    input wire logic i_left_valid,
    input wire logic o_left_valid
);
    // Shadow of config bits, so pin checks need no access to internals
    logic [2:0] cfg_r;
    logic irq_mode_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cfg_r <= 3'h0;
            irq_mode_r <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == ADDR_ZERO_FLAG_CONFIG) begin
            cfg_r <= i_reg_wdata[2:0];
        end else if (i_reg_wr && i_reg_addr == ADDR_ZERO_PIN_FUNCTION) begin
            irq_mode_r <= i_reg_wdata[SHARED_PIN_IRQ_BIT];
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read without data valid");
    AST_RD_QUIET: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("data valid without read");
    AST_UNMAPPED: assert property (i_reg_rd && (i_reg_addr < 7'h66 ||
        i_reg_addr > 7'h68) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RSV_CFG: assert property (i_reg_rd && i_reg_addr == 7'h66
        |=> o_reg_rdata[7:3] == 5'h00) else $error("flag config reserved set");
    AST_RSV_PIN: assert property (i_reg_rd && i_reg_addr == 7'h67
        |=> (o_reg_rdata & 8'h8F) == 8'h00) else $error("pin reserved set");
    AST_GAIN_RW: assert property (i_reg_wr && i_reg_addr == 7'h68
        ##1 !i_reg_wr ##1 i_reg_rd && i_reg_addr == 7'h68
        |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("gain readback");
    AST_VALID_LAT: assert property (i_left_valid ##1 !i_left_valid
        |-> o_left_valid ##1 !o_left_valid) else $error("sample valid timing");
    AST_IRQ_PIN: assert property (irq_mode_r
        |=> o_left_flag_or_irq_pin == $past(i_irq_req))
        else $error("shared pin not irq");
    AST_FLAG_OFF: assert property (cfg_r[2:1] == 2'h3
        && !irq_mode_r |=> o_left_flag_or_irq_pin == $past(cfg_r[0]))
        else $error("disabled flag not idle");
    cover property (irq_mode_r && i_irq_req);
    cover property (i_reg_rd && i_reg_addr == 7'h69);
    cover property (cfg_r[2:1] == 2'h0 && !irq_mode_r);
endmodule : dzfv_props
bind dzfv_top dzfv_props i_props (.i_sys_clk, .i_srst, .i_reg_addr,
    .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
    .i_irq_req, .o_left_flag_or_irq_pin, .i_left_valid, .o_left_valid);

// ===== tb/tb_dac_zero_flag_and_volume_ctrl.sv
/* Self-checking bench for dzfv_top: registers, flag pins, left gain.
   Assumes the one-cycle answers of the register port and flag pins. */
`timescale 1ns/1ps
module tb_dac_zero_flag_and_volume_ctrl;
    import dzfv_pkg::*;
    logic i_sys_clk = 0, i_srst = 1, i_reg_wr = 0, i_reg_rd = 0;
    logic i_left_mute = 0, i_right_mute = 0, i_right_vol_zero = 0;
    logic i_left_zero_data = 0, i_right_zero_data = 0, i_irq_req = 0;
    logic i_left_valid = 0, o_reg_rvalid, o_left_valid;
    logic o_left_flag_or_irq_pin, o_right_channel_flag_pin;
    logic [6:0] i_reg_addr = 7'h00;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, cfg, fun, gain;
    logic [23:0] i_left_sample = 24'h00_0000, o_left_sample;
    logic [7:0] gc[4] = '{8'hFF, 8'hEF, 8'h00, 8'hFF};
    logic [23:0] si[4] = '{24'h10_0000, 24'h10_0000, 24'h10_0000, 24'hF0_0000};
    logic [23:0] so[4] = '{24'h0F_FFE0, 24'h07_FFF0, 24'h00_0010, 24'hF0_0020};
    int n_fail = 0, comparisons = 0, seed = 34;
    initial forever #5 i_sys_clk = ~i_sys_clk;
    dzfv_top i_dut (.i_sys_clk, .i_srst, .i_reg_addr, .i_reg_wr,
        .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_left_mute,
        .i_right_mute, .i_right_vol_zero, .i_left_zero_data,
        .i_right_zero_data, .i_irq_req, .o_left_flag_or_irq_pin,
        .o_right_channel_flag_pin, .i_left_sample, .i_left_valid,
        .o_left_sample, .o_left_valid);
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        chk(24'(got), 24'(exp));
    endtask : chk_reg
    task automatic chk_smp(input logic [23:0] got, input logic [23:0] exp);
        chk(got, exp);
    endtask : chk_smp
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        chk(24'(got), 24'(exp));
    endtask : chk_pin
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        i_reg_rd = 1'b0;
        chk_reg(8'(o_reg_rvalid), 8'h01);
        chk_reg(o_reg_rdata, e);
    endtask : rd
    // Model of both flag pins from shadowed config and live inputs
    function automatic logic [1:0] exp_pins();
        logic l, r, q;
        l = !cfg[2] && (i_left_mute || gain == 8'h00) ||
            !cfg[1] && i_left_zero_data;
        r = !cfg[2] && (i_right_mute || i_right_vol_zero) ||
            !cfg[1] && i_right_zero_data;
        case (fun[5:4])
            2'h0: q = r;
            2'h1: q = l;
            2'h2: q = l | r;
            default: q = l & r;
        endcase
        if (!fun[6]) return {l ^ cfg[0], r ^ cfg[0]};
        return {i_irq_req, q ^ cfg[0]};
    endfunction : exp_pins
    task automatic test_done();
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (2) @(negedge i_sys_clk);
        i_srst = 1'b0;
        rd(ADDR_ZERO_FLAG_CONFIG, ZERO_FLAG_CONFIG_RST);
        rd(ADDR_ZERO_PIN_FUNCTION, ZERO_PIN_FUNCTION_RST);
        rd(ADDR_LEFT_VOLUME, LEFT_VOLUME_RST);
        rd(7'h69, 8'h00);
        wr(7'h69, 8'hFF);
        wr(ADDR_LEFT_VOLUME, 8'hA5);
        rd(ADDR_LEFT_VOLUME, 8'hA5);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_LEFT_VOLUME, gc[i]);
            @(negedge i_sys_clk);
            i_left_sample = si[i];
            i_left_valid = 1'b1;
            @(negedge i_sys_clk);
            i_left_valid = 1'b0;
            chk_smp(o_left_sample, so[i]);
            chk_smp(24'(o_left_valid), 24'h00_0001);
        end
        // Gain forced to zero half the time to reach the volume term
        repeat (40) begin
            cfg = 8'($random(seed));
            fun = 8'($random(seed));
            gain = seed[0] ? 8'h00 : 8'($random(seed));
            wr(ADDR_ZERO_FLAG_CONFIG, cfg);
            wr(ADDR_ZERO_PIN_FUNCTION, fun);
            wr(ADDR_LEFT_VOLUME, gain);
            rd(ADDR_ZERO_FLAG_CONFIG, cfg & ZERO_FLAG_CONFIG_MASK);
            rd(ADDR_ZERO_PIN_FUNCTION, fun & ZERO_PIN_FUNCTION_MASK);
            repeat (4) begin
                @(negedge i_sys_clk);
                {i_left_mute, i_right_mute, i_right_vol_zero, i_left_zero_data,
                    i_right_zero_data, i_irq_req} = 6'($random(seed));
                @(negedge i_sys_clk);
                chk_pin({o_left_flag_or_irq_pin, o_right_channel_flag_pin},
                    exp_pins());
            end
        end
        test_done();
    end
endmodule : tb_dac_zero_flag_and_volume_ctrl
